// >>> inc/fcu_pkg.sv
// Constants, field layout and mode type for the FLL clock source unit
package fcu_pkg;
  // Register byte offsets
  localparam logic [3:0] FCU_OFS_CTRL1 = 4'h0;
  localparam logic [3:0] FCU_OFS_CTRL2 = 4'h4;
  localparam logic [3:0] FCU_OFS_TRIM = 4'h8;
  localparam logic [3:0] FCU_OFS_STATUS = 4'hC;
  // Control 1 fields
  localparam int C1_SRC_POS = 6;
  localparam int C1_REFERENCE_DIVIDER_SELECT_POS = 3;
  localparam int C1_IREF_POS = 2;
  localparam int C1_IRCLKEN_POS = 1;
  localparam int C1_IRSTOP_POS = 0;
  // Control 2 fields
  localparam int C2_BUS_DIVIDER_SELECT_POS = 6;
  localparam int C2_RANGE_POS = 5;
  localparam int C2_GAIN_POS = 4;
  localparam int C2_LP_POS = 3;
  localparam int C2_OSCREQ_POS = 2;
  localparam int C2_EREN_POS = 1;
  localparam int C2_ERSTOP_POS = 0;
  // Status fields
  localparam int ST_MODE_POS = 0;
  localparam int ST_FLL_POS = 3;
  localparam int ST_IRC_POS = 4;
  localparam int ST_EXT_POS = 5;
  // Reset values: FLL source, internal reference, bus divide by 2
  localparam logic [7:0] CTRL1_RST = 8'h04;
  localparam logic [7:0] CTRL2_RST = 8'h40;
  localparam logic [8:0] TRIM_RST = 9'h080;
  // Source select codes
  localparam logic [1:0] SRC_FLL = 2'h0;
  localparam logic [1:0] SRC_INNER = 2'h1;
  localparam logic [1:0] SRC_OUTER = 2'h2;
  // Timing
  localparam int CLK_KHZ = 125000;
  localparam int REF_MAX_KHZ = 5000;
  localparam int REF_MIN_CYC_I = (CLK_KHZ + REF_MAX_KHZ - 1) / REF_MAX_KHZ;
  localparam logic [4:0] REF_MIN_CYC = 5'(REF_MIN_CYC_I);
  localparam logic [9:0] IRC_BASE_PERIOD = 10'h020;
  localparam int FLL_MULT_LOG2 = 4;
  localparam logic [13:0] FLL_PERIOD_RST = 14'h0004;

  typedef enum logic [2:0] {
    LOOP_ENGAGED_INNER_MODE,
    LOOP_ENGAGED_OUTER_MODE,
    LOOP_BYPASSED_INNER_MODE,
    LOOP_BYPASSED_INNER_LOWPWR_MODE,
    LOOP_BYPASSED_OUTER_MODE,
    LOOP_BYPASSED_OUTER_LOWPWR_MODE,
    STOP_MODE
  } fcu_mode_e;

  function automatic logic [6:0] fcu_pow2_mask(input logic [2:0] sel);
    fcu_pow2_mask = 7'((8'h01 << sel) - 8'h01);
  endfunction
endpackage

// >>> inc/fcu_div_if.sv
// Tick and select bundle between the unit and a power-of-two divider
`timescale 1ns/1ns
interface fcu_div_if;
  logic tick;
  logic [2:0] sel;
  logic out;
  modport div (input tick, input sel, output out);
  modport user (output tick, output sel, input out);
endinterface

// >>> core/fcu_pow2_div.sv
// Power-of-two tick divider with registered output
`timescale 1ns/1ns
module fcu_pow2_div
  import fcu_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  fcu_div_if.div port
);
  logic [6:0] count;
  logic hit;

  assign hit = (count & fcu_pow2_mask(port.sel)) == fcu_pow2_mask(port.sel);

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      count <= 7'h00;
    end else if (port.tick) begin
      count <= 7'(count + 7'h01);
    end
  end

  // Only 1..128 ratios exist, a select just picks the counter bit span
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      port.out <= 1'b0;
    end else begin
      port.out <= port.tick && hit;
    end
  end

  property p_out_has_cause;
    @(posedge clk_in) disable iff (!reset_n_in)
    port.out |-> $past(port.tick);
  endproperty
  a_out_has_cause: assert property (p_out_has_cause) else $error("divider tick without input");
endmodule

// >>> core/fcu_clock_source_unit.sv
// FLL clock source unit: mode control, reference paths, bus divider
//
// Function
// - System clock from FLL, inner or outer reference
// - Bus divider ratios 1, 2, 4, 8
// - Bus clock is half of system clock
// - FLL reference up to 5 MHz, divided
// - Nine trim bits tune inner reference
// - Reset lands in loop engaged inner mode
// - Engaged inner: FLL output, inner reference
// - Engaged outer: FLL output, outer reference
// - Bypassed inner: FLL on, inner reference output
// - Bypassed inner low power: FLL off
// - Bypassed outer: FLL on, outer reference output
// - Bypassed outer low power: FLL off
// - Stop: FLL off, no clock, references optional
// - Drive outer oscillator control signals
// - Bus divider codes, reset divide by two
// - Reference divider codes 1..128, reset one
// - Reference select: 0 outer, 1 inner
// - Low power bit turns FLL off in bypass
//
// Implementation choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ns
module fcu_clock_source_unit
  import fcu_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [3:0] avs_address_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic stop_in,
  input wire logic ext_ref_tick_in,
  output logic sys_clk_tick_out,
  output logic bus_clk_tick_out,
  output logic inner_ref_clock_out,
  output logic fll_enabled_out,
  output logic oscillator_gain_select_out,
  output logic osc_range_out,
  output logic oscillator_request_select_out,
  output logic outside_ref_enable_out,
  output logic outside_ref_stop_keep_out
);
  logic [7:0] ctrl1;
  logic [7:0] ctrl2;
  logic [8:0] trim;
  logic [1:0] source_select_field;
  logic [2:0] reference_divider_select;
  logic fll_reference_select;
  logic inner_clk_en;
  logic inner_stop_keep;
  logic [1:0] bus_divider_select;
  logic bypass_fll_off_bit;
  logic outside_ref_enable;
  logic outside_ref_stop_keep;
  fcu_mode_e mode;
  fcu_mode_e next_mode;
  logic was_inner;
  logic fll_on;
  logic irc_run;
  logic ext_run;
  logic [9:0] irc_cnt;
  logic [9:0] irc_period;
  logic irc_tick;
  logic [4:0] ext_gap;
  logic ext_ok;
  logic [17:0] meas;
  logic [13:0] fll_period;
  logic [13:0] dco_cnt;
  logic fll_tick;
  logic src_tick;
  logic half;
  logic req;
  logic [31:0] rd_word;

  fcu_div_if reference_divider_select_if();
  fcu_div_if bus_divider_select_if();

  assign source_select_field = ctrl1[C1_SRC_POS +: 2];
  assign reference_divider_select = ctrl1[C1_REFERENCE_DIVIDER_SELECT_POS +: 3];
  assign fll_reference_select = ctrl1[C1_IREF_POS];
  assign inner_clk_en = ctrl1[C1_IRCLKEN_POS];
  assign inner_stop_keep = ctrl1[C1_IRSTOP_POS];
  assign bus_divider_select = ctrl2[C2_BUS_DIVIDER_SELECT_POS +: 2];
  assign bypass_fll_off_bit = ctrl2[C2_LP_POS];
  assign outside_ref_enable = ctrl2[C2_EREN_POS];
  assign outside_ref_stop_keep = ctrl2[C2_ERSTOP_POS];

  // Avalon slave: every access stalls one cycle, then completes
  assign req = avs_read_in || avs_write_in;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      avs_waitrequest_out <= 1'b1;
    end else if (req && avs_waitrequest_out) begin
      avs_waitrequest_out <= 1'b0;
    end else begin
      avs_waitrequest_out <= 1'b1;
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    case (avs_address_in)
      FCU_OFS_CTRL1: rd_word[7:0] = ctrl1;
      FCU_OFS_CTRL2: rd_word[7:0] = ctrl2;
      FCU_OFS_TRIM: rd_word[8:0] = trim;
      FCU_OFS_STATUS: begin
        rd_word[ST_MODE_POS +: 3] = mode;
        rd_word[ST_FLL_POS] = fll_on;
        rd_word[ST_IRC_POS] = irc_run;
        rd_word[ST_EXT_POS] = ext_run;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (avs_read_in && avs_waitrequest_out) begin
      avs_readdata_out <= rd_word;
    end
  end

  // Reset values leave the unit in engaged inner mode with no write needed
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl1 <= CTRL1_RST;
      ctrl2 <= CTRL2_RST;
      trim <= TRIM_RST;
    end else if (avs_write_in && !avs_waitrequest_out) begin
      case (avs_address_in)
        FCU_OFS_CTRL1: begin
          if (avs_byteenable_in[0]) begin
            ctrl1 <= avs_writedata_in[7:0];
          end
        end
        FCU_OFS_CTRL2: begin
          if (avs_byteenable_in[0]) begin
            ctrl2 <= avs_writedata_in[7:0];
          end
        end
        FCU_OFS_TRIM: begin
          if (avs_byteenable_in[0]) begin
            trim[7:0] <= avs_writedata_in[7:0];
          end
          if (avs_byteenable_in[1]) begin
            trim[8] <= avs_writedata_in[8];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Reserved source code 11 behaves as the FLL source
  always_comb begin
    next_mode = LOOP_ENGAGED_INNER_MODE;
    if (stop_in) begin
      next_mode = STOP_MODE;
    end else begin
      case (source_select_field)
        SRC_INNER: begin
          next_mode = bypass_fll_off_bit ? LOOP_BYPASSED_INNER_LOWPWR_MODE
                                         : LOOP_BYPASSED_INNER_MODE;
        end
        SRC_OUTER: begin
          next_mode = bypass_fll_off_bit ? LOOP_BYPASSED_OUTER_LOWPWR_MODE
                                         : LOOP_BYPASSED_OUTER_MODE;
        end
        default: begin
          next_mode = fll_reference_select ? LOOP_ENGAGED_INNER_MODE
                                           : LOOP_ENGAGED_OUTER_MODE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mode <= LOOP_ENGAGED_INNER_MODE;
    end else begin
      mode <= next_mode;
    end
  end

  // Remember whether the inner reference was in use before stop
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      was_inner <= 1'b1;
    end else if (mode != STOP_MODE) begin
      was_inner <= (mode == LOOP_ENGAGED_INNER_MODE) || (mode == LOOP_BYPASSED_INNER_MODE) ||
                   (mode == LOOP_BYPASSED_INNER_LOWPWR_MODE);
    end
  end

  assign fll_on = (mode == LOOP_ENGAGED_INNER_MODE) || (mode == LOOP_ENGAGED_OUTER_MODE) ||
                  (mode == LOOP_BYPASSED_INNER_MODE) ||
                  (mode == LOOP_BYPASSED_OUTER_MODE);

  // Reference oscillators stay alive while consumed or enabled; in stop only with their stop-keep bit set
  always_comb begin
    if (mode == STOP_MODE) begin
      irc_run = inner_stop_keep && (inner_clk_en || was_inner);
      ext_run = outside_ref_enable && outside_ref_stop_keep;
    end else begin
      irc_run = inner_clk_en || (fll_on && fll_reference_select) ||
                (source_select_field == SRC_INNER);
      ext_run = outside_ref_enable || (fll_on && !fll_reference_select) ||
                (source_select_field == SRC_OUTER);
    end
  end

  // Inner reference model: trim lengthens the period
  assign irc_period = 10'(IRC_BASE_PERIOD + {1'b0, trim});

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irc_cnt <= 10'h000;
      irc_tick <= 1'b0;
    end else if (!irc_run) begin
      irc_cnt <= 10'h000;
      irc_tick <= 1'b0;
    end else if (irc_cnt >= 10'(irc_period - 10'h001)) begin
      irc_cnt <= 10'h000;
      irc_tick <= 1'b1;
    end else begin
      irc_cnt <= 10'(irc_cnt + 10'h001);
      irc_tick <= 1'b0;
    end
  end

  // Outer ticks faster than the reference ceiling are dropped
  assign ext_ok = ext_ref_tick_in && ext_run && (ext_gap == REF_MIN_CYC);

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ext_gap <= REF_MIN_CYC;
    end else if (ext_ok) begin
      ext_gap <= 5'h01;
    end else if (ext_gap != REF_MIN_CYC) begin
      ext_gap <= 5'(ext_gap + 5'h01);
    end
  end

  // Reference path into the FLL
  assign reference_divider_select_if.tick = fll_on && (fll_reference_select ? irc_tick : ext_ok);
  assign reference_divider_select_if.sel = reference_divider_select;

  fcu_pow2_div u_ref_div (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .port(reference_divider_select_if.div)
  );

  // Frequency lock: output period is the reference period over a fixed factor
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meas <= 18'h00000;
      fll_period <= FLL_PERIOD_RST;
    end else if (!fll_on) begin
      meas <= 18'h00000;
      fll_period <= FLL_PERIOD_RST;
    end else if (reference_divider_select_if.out) begin
      meas <= 18'h00001;
      if (meas[17:FLL_MULT_LOG2] != 14'h0000) begin
        fll_period <= meas[17:FLL_MULT_LOG2];
      end
    end else if (meas != 18'h3FFFF) begin
      meas <= 18'(meas + 18'h00001);
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dco_cnt <= 14'h0000;
      fll_tick <= 1'b0;
    end else if (!fll_on) begin
      dco_cnt <= 14'h0000;
      fll_tick <= 1'b0;
    end else if (dco_cnt >= 14'(fll_period - 14'h0001)) begin
      dco_cnt <= 14'h0000;
      fll_tick <= 1'b1;
    end else begin
      dco_cnt <= 14'(dco_cnt + 14'h0001);
      fll_tick <= 1'b0;
    end
  end

  // Source choice per mode; stop passes nothing
  always_comb begin
    case (mode)
      LOOP_ENGAGED_INNER_MODE: src_tick = fll_tick;
      LOOP_ENGAGED_OUTER_MODE: src_tick = fll_tick;
      LOOP_BYPASSED_INNER_MODE: src_tick = irc_tick;
      LOOP_BYPASSED_INNER_LOWPWR_MODE: src_tick = irc_tick;
      LOOP_BYPASSED_OUTER_MODE: src_tick = ext_ok;
      LOOP_BYPASSED_OUTER_LOWPWR_MODE: src_tick = ext_ok;
      default: src_tick = 1'b0;
    endcase
  end

  assign bus_divider_select_if.tick = src_tick;
  assign bus_divider_select_if.sel = {1'b0, bus_divider_select};

  fcu_pow2_div u_bus_div (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .port(bus_divider_select_if.div)
  );

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      half <= 1'b0;
      sys_clk_tick_out <= 1'b0;
      bus_clk_tick_out <= 1'b0;
    end else begin
      sys_clk_tick_out <= bus_divider_select_if.out;
      bus_clk_tick_out <= bus_divider_select_if.out && half;
      if (bus_divider_select_if.out) begin
        half <= !half;
      end
    end
  end

  // Pin-level status and outer oscillator controls
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      inner_ref_clock_out <= 1'b0;
      fll_enabled_out <= 1'b0;
      oscillator_gain_select_out <= 1'b0;
      osc_range_out <= 1'b0;
      oscillator_request_select_out <= 1'b0;
      outside_ref_enable_out <= 1'b0;
      outside_ref_stop_keep_out <= 1'b0;
    end else begin
      inner_ref_clock_out <= irc_tick && inner_clk_en;
      fll_enabled_out <= fll_on;
      oscillator_gain_select_out <= ctrl2[C2_GAIN_POS];
      osc_range_out <= ctrl2[C2_RANGE_POS];
      oscillator_request_select_out <= ctrl2[C2_OSCREQ_POS];
      outside_ref_enable_out <= ext_run;
      outside_ref_stop_keep_out <= outside_ref_stop_keep;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);

  sequence s_stop_held;
    (mode == STOP_MODE) [*3];
  endsequence

  property p_reset_state;
    $rose(reset_n_in) |-> (mode == LOOP_ENGAGED_INNER_MODE) && (bus_divider_select == 2'h1) &&
      (reference_divider_select == 3'h0);
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("bad state after reset");

  property p_stop_no_clock;
    s_stop_held |-> !sys_clk_tick_out && !fll_enabled_out;
  endproperty
  a_stop_no_clock: assert property (p_stop_no_clock) else $error("clock in stop");

  property p_bus_half;
    bus_clk_tick_out |-> sys_clk_tick_out;
  endproperty
  a_bus_half: assert property (p_bus_half) else $error("bus tick without system tick");

  property p_engaged_inner;
    (mode == LOOP_ENGAGED_INNER_MODE) |-> $past(fll_reference_select) ##1 fll_enabled_out;
  endproperty
  a_engaged_inner: assert property (p_engaged_inner) else $error("engaged inner wrong");

  property p_engaged_outer;
    (mode == LOOP_ENGAGED_OUTER_MODE) |-> !$past(fll_reference_select) ##1 fll_enabled_out;
  endproperty
  a_engaged_outer: assert property (p_engaged_outer) else $error("engaged outer wrong");

  property p_lowpwr_off;
    (!stop_in && bypass_fll_off_bit && (source_select_field == SRC_INNER)) |-> ##2
      !fll_enabled_out;
  endproperty
  a_lowpwr_off: assert property (p_lowpwr_off) else $error("FLL on in low power");

  property p_bypass_on;
    (mode == LOOP_BYPASSED_OUTER_MODE) |=> fll_enabled_out;
  endproperty
  a_bypass_on: assert property (p_bypass_on) else $error("FLL off in bypass");

  property p_ref_spacing;
    ext_ok |=> (!ext_ok) [*8];
  endproperty
  a_ref_spacing: assert property (p_ref_spacing) else $error("outer ref too fast");

  property p_mode_follows;
    !stop_in && (source_select_field == SRC_OUTER) && !bypass_fll_off_bit |=>
      (mode == LOOP_BYPASSED_OUTER_MODE);
  endproperty
  a_mode_follows: assert property (p_mode_follows) else $error("mode not derived");
endmodule

// >>> bench/fcu_ext_ref_model.sv
// Outer reference source model: one tick per period while the unit requests it
`timescale 1ns/1ns
module fcu_ext_ref_model (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic enable_in,
  input wire logic [7:0] period_in,
  output logic tick_out
);
  logic [7:0] count;
  // A source that is not requested gives no edges at all
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      count <= 8'h00;
      tick_out <= 1'b0;
    end else if (!enable_in) begin
      count <= 8'h00;
      tick_out <= 1'b0;
    end else if (count >= period_in - 8'h01) begin // Below 25 breaks the rate ceiling
      count <= 8'h00;
      tick_out <= 1'b1;
    end else begin
      count <= count + 8'h01;
      tick_out <= 1'b0;
    end
  end
endmodule

// >>> bench/fcu_clock_source_unit_tb_top.sv
// Self-checking bench for the FLL clock source unit
`timescale 1ns/1ns
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module fcu_clock_source_unit_tb_top;
  import fcu_pkg::*;
  logic clk_in, reset_n_in, avs_read, avs_write, stop, ext_tick;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, rdata, rd;
  logic wait_req, sys_tick, bus_tick, inner_clk, fll_en, gain, range, oscreq, ren, rkeep;
  logic [7:0] ext_period;
  int n_mismatch, n_tests, c_sys, c_bus, c_inner, c_ext;
  logic [7:0] m_c1 [6] = '{8'h04, 8'h00, 8'h44, 8'h44, 8'h80, 8'h80};
  logic [7:0] m_c2 [6] = '{8'h40, 8'h42, 8'h40, 8'h48, 8'h42, 8'h4A};
  logic m_fll [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};

  fcu_clock_source_unit u_dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .avs_read_in(avs_read), .avs_write_in(avs_write), .avs_address_in(avs_address),
    .avs_byteenable_in(avs_byteenable), .avs_writedata_in(avs_writedata),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wait_req), .stop_in(stop),
    .ext_ref_tick_in(ext_tick), .sys_clk_tick_out(sys_tick), .bus_clk_tick_out(bus_tick),
    .inner_ref_clock_out(inner_clk), .fll_enabled_out(fll_en),
    .oscillator_gain_select_out(gain), .osc_range_out(range),
    .oscillator_request_select_out(oscreq), .outside_ref_enable_out(ren),
    .outside_ref_stop_keep_out(rkeep));

  fcu_ext_ref_model u_ref (.clk_in(clk_in), .reset_n_in(reset_n_in), .enable_in(ren),
    .period_in(ext_period), .tick_out(ext_tick));

  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d,
                          input logic [3:0] be);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    @(posedge clk_in);
    while (wait_req !== 1'b0) begin
      @(posedge clk_in);
    end
    rd = rdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic wr32(input logic [3:0] a, input logic [31:0] d);
    bus_xfer(1'b1, a, d, 4'hF);
  endtask

  task automatic rd32(input logic [3:0] a);
    bus_xfer(1'b0, a, 32'h0000_0000, 4'hF);
  endtask

  // Settles for 64 cycles first so a divider change has taken hold
  task automatic count_ticks(input int cycles);
    repeat (64) @(posedge clk_in);
    c_sys = 0;
    c_bus = 0;
    c_inner = 0;
    c_ext = 0;
    repeat (cycles) begin
      @(posedge clk_in);
      c_sys += int'(sys_tick);
      c_bus += int'(bus_tick);
      c_inner += int'(inner_clk);
      c_ext += int'(ext_tick);
    end
  endtask

  function automatic logic near(input int a, input int b);
    return (a - b <= 1) && (b - a <= 1);
  endfunction

  task automatic t_reset();
    rd32(FCU_OFS_CTRL1);
    `CHK(fll_en, 1'b1)
    `CHK(rd, 32'h0000_0004)
    rd32(FCU_OFS_CTRL2);
    `CHK(rd, 32'h0000_0040)
    rd32(FCU_OFS_TRIM);
    `CHK(rd, {23'h0, TRIM_RST})
    rd32(FCU_OFS_STATUS);
    `CHK(rd[2:0], 3'h0)
  endtask

  task automatic t_unmapped();
    wr32(4'h2, 32'h0000_00FF);
    rd32(4'h2);
    `CHK(rd, 32'h0000_0000)
    wr32(FCU_OFS_STATUS, 32'h0000_00FF);
    rd32(FCU_OFS_STATUS);
    `CHK(rd[2:0], 3'h0)
    rd32(FCU_OFS_CTRL1);
    `CHK(rd, 32'h0000_0004)
  endtask

  task automatic t_modes();
    for (int i = 0; i < 6; i++) begin
      wr32(FCU_OFS_CTRL1, {24'h0, m_c1[i]});
      wr32(FCU_OFS_CTRL2, {24'h0, m_c2[i]});
      rd32(FCU_OFS_STATUS);
      `CHK(rd[2:0], 3'(i))
      `CHK(fll_en, m_fll[i])
      `CHK(rd[3], m_fll[i])
    end
  endtask

  task automatic t_bus_div();
    wr32(FCU_OFS_CTRL1, 32'h0000_0080);
    for (int k = 0; k < 4; k++) begin
      wr32(FCU_OFS_CTRL2, {24'h0, 2'(k), 6'h02});
      count_ticks(1024);
      `CHK(near(c_sys, c_ext >> k), 1'b1)
      `CHK(near(c_bus, c_sys / 2), 1'b1)
    end
  endtask

  task automatic t_inner();
    wr32(FCU_OFS_CTRL1, 32'h0000_0046);
    wr32(FCU_OFS_CTRL2, 32'h0000_0000);
    wr32(FCU_OFS_TRIM, 32'h0000_0000);
    count_ticks(1024);
    `CHK(near(c_inner, 32), 1'b1)
    `CHK(near(c_sys, 32), 1'b1)
    wr32(FCU_OFS_TRIM, 32'h0000_0020);
    count_ticks(1024);
    `CHK(near(c_inner, 16), 1'b1)
    bus_xfer(1'b1, FCU_OFS_TRIM, 32'h0000_01FF, 4'h1);
    rd32(FCU_OFS_TRIM);
    `CHK(rd, 32'h0000_00FF)
    bus_xfer(1'b1, FCU_OFS_TRIM, 32'h0000_0100, 4'h2);
    rd32(FCU_OFS_TRIM);
    `CHK(rd, 32'h0000_01FF)
    wr32(FCU_OFS_TRIM, 32'h0000_0000);
    wr32(FCU_OFS_CTRL1, 32'h0000_0044);
    count_ticks(256);
    `CHK(c_inner, 0)
  endtask

  task automatic t_ref_div();
    int e;
    for (int r = 0; r < 8; r++) begin
      wr32(FCU_OFS_CTRL1, {26'h0, 3'(r), 3'h4});
      rd32(FCU_OFS_CTRL1);
      `CHK(rd[5:3], 3'(r))
    end
    // Engaged inner, bus divide 1: FLL period is the divided reference period over 16
    wr32(FCU_OFS_CTRL2, 32'h0000_0000);
    for (int r = 0; r < 4; r += 3) begin
      wr32(FCU_OFS_CTRL1, {26'h0, 3'(r), 3'h4});
      count_ticks(1024);
      count_ticks(1024);
      e = 1024 / ((int'(IRC_BASE_PERIOD) << r) >> FLL_MULT_LOG2);
      `CHK(near(c_sys, e), 1'b1)
    end
  endtask

  task automatic t_osc();
    wr32(FCU_OFS_CTRL2, 32'h0000_0077);
    repeat (2) @(posedge clk_in);
    `CHK({gain, range, oscreq, ren, rkeep}, 5'h1F)
    wr32(FCU_OFS_CTRL2, 32'h0000_0040);
    repeat (2) @(posedge clk_in);
    `CHK({gain, range, oscreq, ren, rkeep}, 5'h00)
  endtask

  task automatic t_stop();
    wr32(FCU_OFS_CTRL1, 32'h0000_0007);
    stop <= 1'b1;
    @(posedge clk_in);
    rd32(FCU_OFS_STATUS);
    `CHK(rd[2:0], 3'h6)
    `CHK(fll_en, 1'b0)
    count_ticks(256);
    `CHK(c_sys, 0)
    `CHK(c_inner > 0, 1'b1)
    stop <= 1'b0;
    @(posedge clk_in);
    rd32(FCU_OFS_STATUS);
    `CHK(rd[2:0], 3'h0)
  endtask

  // Period 10 is too fast: only every third outer tick may be accepted
  task automatic t_refuse();
    wr32(FCU_OFS_CTRL1, 32'h0000_0080);
    wr32(FCU_OFS_CTRL2, 32'h0000_0002);
    ext_period <= 8'h0A;
    count_ticks(1200);
    `CHK(near(c_sys, c_ext / 3), 1'b1)
    ext_period <= 8'h20;
  endtask

  initial begin
    n_mismatch = 0;
    n_tests = 0;
    reset_n_in = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_byteenable = 4'h0;
    avs_writedata = 32'h0000_0000;
    stop = 1'b0;
    ext_period = 8'h20;
    repeat (2) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(posedge clk_in);
    t_reset();
    t_unmapped();
    t_modes();
    t_bus_div();
    t_inner();
    t_ref_div();
    t_osc();
    t_stop();
    t_refuse();
    complete_run();
  end

  // Runs take about 13000 cycles; over four times that means a hang
  initial begin
    #(60000 * 8);
    n_mismatch++;
    complete_run();
  end
endmodule
